// ### src/acrb_regs.sv
// acrb_regs: powerdown, extended feature, sample rate, chain routing and
// vendor registers of the codec, with warm / cold reset of the link.
// assumes the link frame logic on bit_clk delivers decoded commands and the
// device's own return bit; registers live on mclk.
`timescale 1ns/10ps
module acrb_regs (
   // system clock and reset
   input  wire logic              mclk,
   input  wire logic              srst,
   // link pins
   input  wire logic              bit_clk,
   input  wire logic              reset_n,
   input  wire logic              frame_sync,
   input  wire logic              chain_input,
   output logic                   sdata_return,
   output logic                   bit_clk_run,
   // identity straps
   input  wire logic              identity_strap_high_n,
   input  wire logic              identity_strap_low_n,
   // subsection readiness, one bit per subsection
   input  wire logic [3:0]        status_ready,
   // decoded commands, bit_clk domain
   input  wire logic              cmd_valid,
   input  wire acrb_pkg::acrb_cmd_s cmd,
   output logic                   cmd_ready,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_rdata,
   input  wire logic              own_sdata,
   // controls to the analog and clock sections
   output acrb_pkg::acrb_pd_s     powerdown,
   output logic                   mixer_circuit_off,
   output logic                   vref_off,
   output logic                   ext_amp_powerdown,
   output logic                   internal_clock_stop,
   output logic                   link_powered_down,
   output logic                   variable_rate_enable,
   output logic [15:0]            dac_rate,
   output logic [15:0]            adc_rate
);

   localparam int IDLE_W = $clog2(acrb_pkg::WARM_IDLE_CYC + 1);
   localparam logic [IDLE_W-1:0] IDLE_MAX = IDLE_W'(acrb_pkg::WARM_IDLE_CYC);

   // ---------------- mclk side declarations
   logic              cold_s1, cold_s2;
   logic              fs_m1, fs_m2;
   logic              blk_s1, blk_s2, blk_s3;
   logic              req_s1, req_s2, req_s3;
   logic [1:0]        strap_s1, strap_s2;
   logic [3:0]        stat_s1, stat_s2;
   logic [IDLE_W-1:0] idle_cnt_r;
   acrb_pkg::acrb_pd_s pwr_ctrl_r;
   logic              vra_r;
   logic [15:0]       dac_reg_r, adc_reg_r;
   logic [15:0]       dac_rate_r, adc_rate_r;
   logic [1:0]        chain_r;
   logic [15:0]       rd_data_r, rd_data_nxt;
   logic              ack_tgl_r;
   logic              chain_on_m_r;
   logic              bit_clk_run_r;
   logic              mix_off_r, vref_off_r;
   logic              rst_all, req_hit, wr_hit, soft_rst, warm_hit, blk_active;
   logic [1:0]        identity;

   // ---------------- bit_clk side declarations
   logic              lrst_s1, lrst_s2;
   logic              fs_l1, fs_l2, fs_l3;
   logic              pd_s1, pd_s2;
   logic              con_s1, con_s2;
   logic              ack_s1, ack_s2, ack_s3;
   logic              blk_tgl_r;
   logic              req_tgl_r;
   logic              pend_r;
   acrb_pkg::acrb_cmd_s cmd_hold_r;
   logic              rsp_valid_r;
   logic [15:0]       rsp_rdata_r;
   logic              chain_on_l_r;
   logic              fs_rise, ack_hit;

   // ================= mclk domain
   always_ff @(posedge mclk) begin
      cold_s1  <= reset_n;
      cold_s2  <= cold_s1;
      fs_m1    <= frame_sync;
      fs_m2    <= fs_m1;
      blk_s1   <= blk_tgl_r;
      blk_s2   <= blk_s1;
      blk_s3   <= blk_s2;
      req_s1   <= req_tgl_r;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
      strap_s1 <= {identity_strap_high_n, identity_strap_low_n};
      strap_s2 <= strap_s1;
      stat_s1  <= status_ready;
      stat_s2  <= stat_s1;
   end

   assign identity   = ~strap_s2;
   assign rst_all    = srst | ~cold_s2;
   assign req_hit    = req_s2 ^ req_s3;
   assign wr_hit     = req_hit & cmd_hold_r.write;
   assign soft_rst   = wr_hit & (cmd_hold_r.addr == acrb_pkg::REG_RESET);
   assign blk_active = blk_s2 ^ blk_s3;

   // warm reset needs frame sync high with the bit clock stood still
   always_ff @(posedge mclk) begin
      if (rst_all || blk_active) begin
         idle_cnt_r <= '0;
      end else if (idle_cnt_r != IDLE_MAX) begin
         idle_cnt_r <= idle_cnt_r + IDLE_W'(1);
      end
   end

   assign warm_hit = fs_m2 & (idle_cnt_r == IDLE_MAX) & pwr_ctrl_r.link_interface_powerdown;

   // powerdown control bits; status bits are never stored
   always_ff @(posedge mclk) begin
      if (rst_all || soft_rst) begin
         pwr_ctrl_r <= acrb_pkg::PWR_CTRL_RST;
      end else if (warm_hit) begin
         pwr_ctrl_r.link_interface_powerdown <= 1'b0;
      end else if (wr_hit && cmd_hold_r.addr == acrb_pkg::REG_PWR) begin
         pwr_ctrl_r <= cmd_hold_r.wdata[15:acrb_pkg::PWR_CTRL_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst_all || soft_rst) begin
         vra_r     <= acrb_pkg::VRA_RST;
         dac_reg_r <= acrb_pkg::RATE_RST;
         adc_reg_r <= acrb_pkg::RATE_RST;
      end else if (wr_hit) begin
         if (cmd_hold_r.addr == acrb_pkg::REG_EXT_CTRL) begin
            vra_r <= cmd_hold_r.wdata[acrb_pkg::VRA_BIT];
         end
         if (cmd_hold_r.addr == acrb_pkg::REG_DAC_RATE) begin
            dac_reg_r <= cmd_hold_r.wdata;
         end
         if (cmd_hold_r.addr == acrb_pkg::REG_ADC_RATE) begin
            adc_reg_r <= cmd_hold_r.wdata;
         end
      end
   end

   // chain routing resets to the identity, so the codec drives its own frames
   always_ff @(posedge mclk) begin
      if (rst_all || soft_rst) begin
         chain_r <= identity;
      end else if (wr_hit && cmd_hold_r.addr == acrb_pkg::REG_CHAIN) begin
         chain_r <= cmd_hold_r.wdata[acrb_pkg::CHAIN_LSB +: 2];
      end
   end

   // sampling at frame rate unless the variable rate bit is set
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         dac_rate_r <= acrb_pkg::RATE_RST;
         adc_rate_r <= acrb_pkg::RATE_RST;
      end else begin
         dac_rate_r <= vra_r ? dac_reg_r : acrb_pkg::RATE_RST;
         adc_rate_r <= vra_r ? adc_reg_r : acrb_pkg::RATE_RST;
      end
   end

   // decoded powerdown controls
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         mix_off_r     <= 1'b0;
         vref_off_r    <= 1'b0;
         bit_clk_run_r <= 1'b0;
         chain_on_m_r  <= 1'b0;
      end else begin
         mix_off_r     <= pwr_ctrl_r.mixer_powerdown_ref_on
                        | pwr_ctrl_r.mixer_powerdown_ref_off;
         vref_off_r    <= pwr_ctrl_r.mixer_powerdown_ref_off;
         // clock disable leaves the bit clock alone
         bit_clk_run_r <= (identity == 2'h0)
                        & ~pwr_ctrl_r.link_interface_powerdown;
         chain_on_m_r  <= (chain_r != identity);
      end
   end

   always_comb begin
      rd_data_nxt = acrb_pkg::RSVD_READ;
      unique case (cmd_hold_r.addr)
         acrb_pkg::REG_RESET:    rd_data_nxt = acrb_pkg::RESET_REG_READ;
         acrb_pkg::REG_PWR: begin
            rd_data_nxt[15:acrb_pkg::PWR_CTRL_LSB] = pwr_ctrl_r;
            rd_data_nxt[acrb_pkg::PWR_STATUS_LSB +: acrb_pkg::PWR_STATUS_W] = stat_s2;
         end
         acrb_pkg::REG_EXT_ID: begin
            rd_data_nxt[acrb_pkg::EXT_ID_ID_LSB +: 2] = identity;
            rd_data_nxt[acrb_pkg::EXT_ID_MAP_BIT]     = 1'b1;
            rd_data_nxt[acrb_pkg::EXT_ID_VRA_BIT]     = 1'b1;
         end
         acrb_pkg::REG_EXT_CTRL: rd_data_nxt[acrb_pkg::VRA_BIT] = vra_r;
         acrb_pkg::REG_DAC_RATE: rd_data_nxt = dac_reg_r;
         acrb_pkg::REG_ADC_RATE: rd_data_nxt = adc_reg_r;
         acrb_pkg::REG_CHAIN:    rd_data_nxt[acrb_pkg::CHAIN_LSB +: 2] = chain_r;
         acrb_pkg::REG_VID_HI:   rd_data_nxt = acrb_pkg::VENDOR_CHARS[23:8];
         acrb_pkg::REG_VID_LO:   rd_data_nxt = {acrb_pkg::VENDOR_CHARS[7:0],
                                                acrb_pkg::PART_BCD};
         default:                rd_data_nxt = acrb_pkg::RSVD_READ;
      endcase
   end

   // read data is settled before the answer toggle crosses back
   always_ff @(posedge mclk) begin
      if (rst_all) begin
         rd_data_r <= '0;
         ack_tgl_r <= 1'b0;
      end else if (req_hit) begin
         rd_data_r <= rd_data_nxt;
         ack_tgl_r <= ~ack_tgl_r;
      end
   end

   assign powerdown            = pwr_ctrl_r;
   assign ext_amp_powerdown    = pwr_ctrl_r.ext_amp_powerdown;
   assign internal_clock_stop  = pwr_ctrl_r.internal_clock_disable;
   assign link_powered_down    = pwr_ctrl_r.link_interface_powerdown;
   assign mixer_circuit_off    = mix_off_r;
   assign vref_off             = vref_off_r;
   assign variable_rate_enable = vra_r;
   assign dac_rate             = dac_rate_r;
   assign adc_rate             = adc_rate_r;
   assign bit_clk_run          = bit_clk_run_r;

   // ================= bit_clk domain
   // link reset only acts while the bit clock runs
   always_ff @(posedge bit_clk) begin
      lrst_s1 <= srst | ~reset_n;
      lrst_s2 <= lrst_s1;
      fs_l1   <= frame_sync;
      fs_l2   <= fs_l1;
      fs_l3   <= fs_l2;
      pd_s1   <= pwr_ctrl_r.link_interface_powerdown;
      pd_s2   <= pd_s1;
      con_s1  <= chain_on_m_r;
      con_s2  <= con_s1;
      ack_s1  <= ack_tgl_r;
      ack_s2  <= ack_s1;
      ack_s3  <= ack_s2;
   end

   assign fs_rise = fs_l2 & ~fs_l3;
   assign ack_hit = ack_s2 ^ ack_s3;

   always_ff @(posedge bit_clk) begin
      if (lrst_s2) begin
         blk_tgl_r <= 1'b0;
      end else begin
         blk_tgl_r <= ~blk_tgl_r;
      end
   end

   // no control exchange while the link interface is down
   assign cmd_ready = ~pend_r & ~pd_s2 & ~lrst_s2;

   always_ff @(posedge bit_clk) begin
      if (lrst_s2) begin
         req_tgl_r   <= 1'b0;
         pend_r      <= 1'b0;
         cmd_hold_r  <= '0;
         rsp_valid_r <= 1'b0;
         rsp_rdata_r <= '0;
      end else begin
         rsp_valid_r <= ack_hit;
         if (ack_hit) begin
            pend_r      <= 1'b0;
            rsp_rdata_r <= rd_data_r;
         end else if (cmd_valid && cmd_ready) begin
            pend_r     <= 1'b1;
            cmd_hold_r <= cmd;
            req_tgl_r  <= ~req_tgl_r;
         end
      end
   end

   assign rsp_valid = rsp_valid_r;
   assign rsp_rdata = rsp_rdata_r;

   always_ff @(posedge bit_clk) begin
      if (lrst_s2) begin
         chain_on_l_r <= 1'b0;
      end else if (fs_rise) begin
         chain_on_l_r <= con_s2;
      end
   end

   // pass-through is wired, the chain bit is not retimed
   assign sdata_return = pd_s2 ? 1'b0 : (chain_on_l_r ? chain_input : own_sdata);

   // ================= checks, mclk
   sequence pwr_write_s;
      wr_hit && cmd_hold_r.addr == acrb_pkg::REG_PWR;
   endsequence

   chk_ext_amp_powerdown_pin_follows: assert property (@(posedge mclk) disable iff (rst_all)
      (pwr_write_s and !soft_rst and !warm_hit) |=>
      ext_amp_powerdown == $past(cmd_hold_r.wdata[15]))
      else $error("amp pin not following bit 15");

   chk_vref_mixer_off: assert property (@(posedge mclk) disable iff (rst_all)
      vref_off |-> mixer_circuit_off)
      else $error("reference off without mixers off");

   chk_link_pd_clock: assert property (@(posedge mclk) disable iff (rst_all)
      pwr_ctrl_r.link_interface_powerdown |=> !bit_clk_run)
      else $error("bit clock runs during link powerdown");

   chk_cold_defaults: assert property (@(posedge mclk) disable iff (srst)
      !cold_s2 |=> pwr_ctrl_r == acrb_pkg::PWR_CTRL_RST && chain_r == identity
                   && !vra_r && dac_reg_r == acrb_pkg::RATE_RST)
      else $error("cold reset left a register off default");

   chk_warm_only_link: assert property (@(posedge mclk) disable iff (rst_all)
      (warm_hit && !soft_rst) |=> !pwr_ctrl_r.link_interface_powerdown
      && pwr_ctrl_r.adc_path_powerdown == $past(pwr_ctrl_r.adc_path_powerdown)
      && $stable(vra_r) && $stable(chain_r) && $stable(dac_reg_r))
      else $error("warm reset disturbed other registers");

   chk_ext_id_read: assert property (@(posedge mclk) disable iff (rst_all)
      (req_hit && cmd_hold_r.addr == acrb_pkg::REG_EXT_ID) |=>
      rd_data_r == {~$past(strap_s2), 4'h0, 1'b1, 8'h00, 1'b1})
      else $error("extended id read wrong");

   chk_rate_fallback: assert property (@(posedge mclk) disable iff (rst_all)
      !vra_r |=> dac_rate == acrb_pkg::RATE_RST && adc_rate == acrb_pkg::RATE_RST)
      else $error("rate applied with variable rate off");

   chk_rate_store: assert property (@(posedge mclk) disable iff (rst_all)
      (wr_hit && !soft_rst && cmd_hold_r.addr == acrb_pkg::REG_ADC_RATE) |=>
      adc_reg_r == $past(cmd_hold_r.wdata) ##2 (!vra_r || adc_rate == adc_reg_r))
      else $error("rate register not stored or applied");

   chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst_all)
      (req_hit && (cmd_hold_r.addr == acrb_pkg::REG_RSVD_A
                   || cmd_hold_r.addr == acrb_pkg::REG_RSVD_C)) |=> rd_data_r == 16'h0000)
      else $error("reserved register read nonzero");

   chk_reg_reset: assert property (@(posedge mclk) disable iff (rst_all)
      soft_rst |=> pwr_ctrl_r == acrb_pkg::PWR_CTRL_RST && !vra_r
                   && adc_reg_r == acrb_pkg::RATE_RST)
      else $error("register reset incomplete");

   chk_status_ro: assert property (@(posedge mclk) disable iff (rst_all)
      (req_hit && cmd_hold_r.addr == acrb_pkg::REG_PWR) |=>
      rd_data_r[3:0] == $past(stat_s2))
      else $error("status bits not from subsections");

   // ================= checks, bit_clk
   chk_chain_on_edge: assert property (@(posedge bit_clk) disable iff (lrst_s2)
      $changed(chain_on_l_r) |-> $past(fs_rise))
      else $error("chain routing changed off frame edge");

   chk_chain_pass: assert property (@(posedge bit_clk) disable iff (lrst_s2)
      (chain_on_l_r && !pd_s2) |-> sdata_return == chain_input)
      else $error("chain input not passed through");

endmodule

// ### shared/acrb_pkg.sv
// acrb_pkg: register map, field layout, reset values and timing of the
// codec powerdown / rate / chain register bank.
// assumes a 50 MHz system clock and a 7-bit register index from the link.
package acrb_pkg;

   // register offsets
   localparam logic [6:0] REG_RESET    = 7'h00;
   localparam logic [6:0] REG_RSVD_A   = 7'h24;
   localparam logic [6:0] REG_PWR      = 7'h26;
   localparam logic [6:0] REG_EXT_ID   = 7'h28;
   localparam logic [6:0] REG_EXT_CTRL = 7'h2a;
   localparam logic [6:0] REG_DAC_RATE = 7'h2c;
   localparam logic [6:0] REG_ADC_RATE = 7'h32;
   localparam logic [6:0] REG_RSVD_B   = 7'h5a;
   localparam logic [6:0] REG_CHAIN    = 7'h74;
   localparam logic [6:0] REG_RSVD_C   = 7'h7a;
   localparam logic [6:0] REG_VID_HI   = 7'h7c;
   localparam logic [6:0] REG_VID_LO   = 7'h7e;

   // field positions
   localparam int PWR_STATUS_LSB = 0;
   localparam int PWR_STATUS_W   = 4;
   localparam int PWR_CTRL_LSB   = 8;
   localparam int EXT_ID_VRA_BIT = 0;
   localparam int EXT_ID_MAP_BIT = 9;
   localparam int EXT_ID_ID_LSB  = 14;
   localparam int VRA_BIT        = 0;
   localparam int CHAIN_LSB      = 0;

   // reset and fixed read values
   localparam logic [7:0]  PWR_CTRL_RST   = 8'h00;
   localparam logic        VRA_RST        = 1'b0;
   localparam logic [15:0] RATE_RST       = 16'hbb80;
   localparam logic [15:0] RESET_REG_READ = 16'h0d50;
   localparam logic [15:0] RSVD_READ      = 16'h0000;

   // vendor identity, values arbitrary
   localparam logic [23:0] VENDOR_CHARS = 24'h414243;
   localparam logic [7:0]  PART_BCD     = 8'h12;

   // timing
   localparam int MCLK_MHZ      = 50;
   localparam int WARM_IDLE_NS  = 1000;
   localparam int WARM_IDLE_CYC = (WARM_IDLE_NS * MCLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic        write;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } acrb_cmd_s;

   // bit 15 down to bit 8 of the powerdown register
   typedef struct packed {
      logic ext_amp_powerdown;
      logic headphone_amp_powerdown;
      logic internal_clock_disable;
      logic link_interface_powerdown;
      logic mixer_powerdown_ref_off;
      logic mixer_powerdown_ref_on;
      logic dac_path_powerdown;
      logic adc_path_powerdown;
   } acrb_pd_s;

endpackage

// ### verification/acrb_ctrl_model.sv
// acrb_ctrl_model: controller side of the link; makes bit clock, frame sync
// and decoded register commands. assumes its tasks are called one at a time.
`timescale 1ns/10ps
module acrb_ctrl_model (
   // link pins
   output logic                bit_clk,
   output logic                frame_sync,
   // command port
   output logic                cmd_valid,
   output acrb_pkg::acrb_cmd_s cmd,
   input  wire logic           cmd_ready,
   input  wire logic           rsp_valid
);
   logic run;
   int   n;

   initial begin
      bit_clk = 1'b0;
      frame_sync = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      run = 1'b1;
      forever begin
         #80;
         if (run) begin
            bit_clk = ~bit_clk;
         end
      end
   end

   // request moves on the falling edge; ready only changes on the rising
   // edge, so seen high here it still stands at the taking edge
   task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d);
      @(negedge bit_clk);
      cmd_valid = 1'b1;
      cmd = '{wr, a, d};
      n = 0;
      while (cmd_ready !== 1'b1 && n < 60) begin
         @(negedge bit_clk);
         n++;
      end
      @(posedge bit_clk);
      @(negedge bit_clk);
      cmd_valid = 1'b0;
      // stale command inverted so it never looks valid
      cmd = acrb_pkg::acrb_cmd_s'(~cmd);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
         @(negedge bit_clk);
         n++;
      end
      @(posedge bit_clk);
   endtask

   task automatic sync_pulse();
      repeat (4) @(negedge bit_clk);
      frame_sync = 1'b1;
      repeat (4) @(negedge bit_clk);
      frame_sync = 1'b0;
      repeat (4) @(posedge bit_clk);
   endtask

   task automatic warm();
      #82800;
      @(negedge bit_clk);
      run = 1'b0;
      frame_sync = 1'b1;
      #2000;
      frame_sync = 1'b0;
      #200;
      run = 1'b1;
      repeat (8) @(posedge bit_clk);
   endtask
endmodule

// ### verification/tb_audio_codec_power_rate_chain_regs.sv
// tb_audio_codec_power_rate_chain_regs: self-checking bench of the register
// bank; controller model drives commands, a monitor checks every read answer.
`timescale 1ns/10ps
module tb_audio_codec_power_rate_chain_regs;
   logic                mclk, srst, reset_n, chain_input, own_sdata;
   logic                id_hi_n, id_lo_n, bit_clk, frame_sync, cmd_valid;
   logic                cmd_ready, rsp_valid, sdata_return, bit_clk_run;
   logic                mixer_circuit_off, vref_off, ext_amp_powerdown;
   logic                internal_clock_stop, link_powered_down, variable_rate_enable;
   logic [3:0]          st;
   logic [15:0]         rsp_rdata, dac_rate, adc_rate, r1, r2;
   logic [16:0]         note;
   acrb_pkg::acrb_cmd_s cmd;
   acrb_pkg::acrb_pd_s  powerdown;
   logic [16:0]         expq[$];
   int                  err_total, num_checks, cyc;
   logic [6:0]  ra [12] = '{7'h28, 7'h2a, 7'h2c, 7'h32, 7'h74, 7'h7c,
                            7'h7e, 7'h24, 7'h5a, 7'h7a, 7'h30, 7'h00};
   logic [15:0] rv [12] = '{16'h0201, 16'h0000, 16'hbb80, 16'hbb80, 16'h0000, 16'h4142,
                            16'h4312, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0d50};

   acrb_ctrl_model ctl (.bit_clk(bit_clk), .frame_sync(frame_sync), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid));

   acrb_regs DUT (.mclk(mclk), .srst(srst), .bit_clk(bit_clk), .reset_n(reset_n),
      .frame_sync(frame_sync), .chain_input(chain_input), .sdata_return(sdata_return),
      .bit_clk_run(bit_clk_run), .identity_strap_high_n(id_hi_n),
      .identity_strap_low_n(id_lo_n), .status_ready(st), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .own_sdata(own_sdata), .powerdown(powerdown), .mixer_circuit_off(mixer_circuit_off),
      .vref_off(vref_off), .ext_amp_powerdown(ext_amp_powerdown),
      .internal_clock_stop(internal_clock_stop), .link_powered_down(link_powered_down),
      .variable_rate_enable(variable_rate_enable), .dac_rate(dac_rate),
      .adc_rate(adc_rate));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      expq.push_back({1'b1, e});
      ctl.xfer(1'b0, a, 16'h0000);
   endtask

   // answers to writes carry the old value, not compared
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      expq.push_back({1'b0, 16'h0000});
      ctl.xfer(1'b1, a, d);
   endtask

   // m: 0 own frames, 1 chain input, 2 held low
   task automatic watch(input int m);
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         chk("sdata_return", m == 0 ? own_sdata : (m == 1 ? chain_input : 1'b0),
             sdata_return);
      end
   endtask

   always @(negedge bit_clk) begin
      if (rsp_valid === 1'b1) begin
         if (expq.size() == 0) begin
            chk("rsp_count", 16'h0000, 16'h0001);
         end else begin
            note = expq.pop_front();
            if (note[16]) begin
               chk("rsp_rdata", note[15:0], rsp_rdata);
            end
         end
      end
   end

   always @(negedge mclk) begin
      chain_input <= 1'($urandom);
      own_sdata <= 1'($urandom);
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(32'h97bc));
      srst = 1'b1;
      reset_n = 1'b0;
      id_hi_n = 1'b1;
      id_lo_n = 1'b1;
      st = 4'($urandom);
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      srst = 1'b0;
      repeat (25) @(negedge mclk);
      reset_n = 1'b1;
      repeat (20) @(negedge mclk);
      rd(7'h26, {12'h000, st});
      for (int i = 0; i < 12; i++) begin
         rd(ra[i], rv[i]);
      end
      wr(7'h26, 16'haf0f);
      rd(7'h26, {8'haf, 4'h0, st});
      repeat (4) @(negedge mclk);
      chk("powerdown", 16'h00af, 16'(powerdown));
      chk("ext_amp", 16'h0001, ext_amp_powerdown);
      chk("clock_stop", 16'h0001, internal_clock_stop);
      chk("bit_clk_run", 16'h0001, bit_clk_run);
      chk("vref_off", 16'h0001, vref_off);
      wr(7'h26, 16'h0400);
      repeat (4) @(negedge mclk);
      chk("mixer_off", 16'h0001, mixer_circuit_off);
      chk("vref_off", 16'h0000, vref_off);
      chk("ext_amp", 16'h0000, ext_amp_powerdown);
      r1 = 16'(4000 + $urandom % 44001);
      r2 = 16'(4000 + $urandom % 44001);
      wr(7'h2c, r1);
      wr(7'h32, r2);
      repeat (4) @(negedge mclk);
      chk("dac_rate", 16'hbb80, dac_rate);
      chk("adc_rate", 16'hbb80, adc_rate);
      wr(7'h2a, 16'h0001);
      repeat (4) @(negedge mclk);
      chk("vra", 16'h0001, variable_rate_enable);
      chk("dac_rate", r1, dac_rate);
      chk("adc_rate", r2, adc_rate);
      rd(7'h32, r2);
      wr(7'h74, 16'hfff1);
      rd(7'h74, 16'h0001);
      watch(0);
      ctl.sync_pulse();
      watch(1);
      wr(7'h00, 16'h1234);
      rd(7'h74, 16'h0000);
      rd(7'h2a, 16'h0000);
      rd(7'h2c, 16'hbb80);
      ctl.sync_pulse();
      watch(0);
      wr(7'h2a, 16'h0001);
      wr(7'h26, 16'h1000);
      repeat (8) @(negedge mclk);
      chk("link_pd", 16'h0001, link_powered_down);
      chk("bit_clk_run", 16'h0000, bit_clk_run);
      chk("cmd_ready", 16'h0000, cmd_ready);
      watch(2);
      ctl.warm();
      rd(7'h26, {12'h000, st});
      rd(7'h2a, 16'h0001);
      @(negedge mclk);
      id_hi_n = 1'b0;
      reset_n = 1'b0;
      repeat (40) @(negedge mclk);
      reset_n = 1'b1;
      repeat (20) @(negedge mclk);
      chk("bit_clk_run", 16'h0000, bit_clk_run);
      rd(7'h28, 16'h8201);
      rd(7'h74, 16'h0002);
      rd(7'h2a, 16'h0000);
      watch(0);
      repeat (4) @(negedge bit_clk);
      chk("queue", 16'h0000, 16'(expq.size()));
      stop_test();
   end
endmodule
